// ---- rtl/adcc_defs.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the converter control block
// Assumes: Avalon-MM word addressing of 32-bit registers, register indices listed here
// Notes:   Shared by the control block and its conversion clock period generator
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH

`define ADCC_ADDR_CTRL0      4'h0
`define ADCC_ADDR_CTRL1      4'h1
`define ADCC_ADDR_RES_HIGH   4'h2
`define ADCC_ADDR_RES_LOW    4'h3
`define ADCC_ADDR_IRQ_STAT   4'h4
`define ADCC_ADDR_IRQ_MASK   4'h5

`define ADCC_BIT_ENABLE      0
`define ADCC_BIT_GO          1
`define ADCC_CHS_LSB         2
`define ADCC_CHS_MSB         6
`define ADCC_CKS_LSB         4
`define ADCC_CKS_MSB         6

`define ADCC_CKS_OSC8        3'b001
`define ADCC_CKS_OSC16       3'b101
`define ADCC_CKS_OSC32       3'b010
`define ADCC_CKS_OSC64       3'b110
`define ADCC_CKS_RC_LOW      2'b11
`define ADCC_DIV_OSC8        8
`define ADCC_DIV_OSC16       16
`define ADCC_DIV_OSC32       32
`define ADCC_DIV_OSC64       64

`define ADCC_CTRL0_WMASK     8'h7f
`define ADCC_CTRL1_WMASK     8'h70
`define ADCC_CTRL_RESET      8'h00

`define ADCC_CHS_INT_LAST    5'h0c
`define ADCC_CHS_EXT_FIRST   5'h10
`define ADCC_CHS_EXT_LAST    5'h17
`define ADCC_CHS_SMALL_LAST  5'h15

`define ADCC_CONV_TADS       4'hb
`define ADCC_ABORT_TADS      4'h2
`define ADCC_RC_DIV          8'h10
`define ADCC_TAD_CNT_W       8

`define ADCC_IRQ_DONE_BIT    0
`define ADCC_IRQ_ABORT_BIT   1

`endif

// ---- rtl/adcc_pkg.sv ----
// Purpose: Types of the converter control block
// Assumes: Nothing beyond the defines header
// Notes:   States use Gray codes along idle, convert, done, then settle
package adcc_pkg;
    typedef enum logic [1:0] {
        ADCC_IDLE    = 2'b00,
        ADCC_CONVERT = 2'b01,
        ADCC_DONE    = 2'b11,
        ADCC_SETTLE  = 2'b10
    } adcc_state_e;
endpackage

// ---- rtl/adcc_tad_gen.sv ----
// Purpose: Conversion clock period enable generator
// Assumes: i_rc_tick is already a one-cycle enable in the core domain
// Notes:   Emits one-cycle pulse per conversion clock period
`timescale 1ns/100ps
`include "adcc_defs.svh"
module adcc_tad_gen #(
    parameter int CNT_W = `ADCC_TAD_CNT_W
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_run,
    input  wire logic [2:0]       i_clk_sel,
    input  wire logic             i_rc_tick,
    output logic                  o_tad_tick
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] div_last;
    logic             tick_next;
    logic             use_rc;

    always_comb begin
        use_rc = (i_clk_sel[1:0] == `ADCC_CKS_RC_LOW);
        case (i_clk_sel)
            `ADCC_CKS_OSC8:  div_last = CNT_W'(`ADCC_DIV_OSC8 - 1);
            `ADCC_CKS_OSC16: div_last = CNT_W'(`ADCC_DIV_OSC16 - 1);
            `ADCC_CKS_OSC32: div_last = CNT_W'(`ADCC_DIV_OSC32 - 1);
            `ADCC_CKS_OSC64: div_last = CNT_W'(`ADCC_DIV_OSC64 - 1);
            default: div_last = '0;
        endcase
        cnt_next  = cnt_reg;
        tick_next = 1'b0;
        if (!i_run) begin
            cnt_next = '0;
        end else if (use_rc) begin
            tick_next = i_rc_tick;
        end else if (div_last != '0) begin
            if (cnt_reg >= div_last) begin
                cnt_next  = '0;
                tick_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_reg    <= '0;
            o_tad_tick <= 1'b0;
        end else begin
            cnt_reg    <= cnt_next;
            o_tad_tick <= tick_next;
        end
    end
endmodule

// ---- rtl/adcc_top.sv ----
// What this block does
// R01: Channel codes 00-0C internal, 10-17 external pins
// R02: Writing go starts; hardware clears it when done
// R03: Enable clear keeps converter off, no current
// R04: Clock select picks osc divide or RC
// R05: RC option divides internal oscillator by sixteen
// R06: Top two result bits in high register
// R07: Low eight result bits in low register
// R08: Unimplemented control bits read zero, ignore writes
// R09: Control fields reset to zero
// R10: Codes 10110, 10111 unimplemented on small package
// R11: Software waits acquisition time before starting
// R12: Hold capacitor never discharged between conversions
// R13: Conversion lasts eleven conversion clock periods
// R14: Completion clears go, flags, loads result
// R15: Abort keeps result; two-period delay follows
// R16: Done flag always set; only software clears
// R17: Start while disabled is ignored, reads zero
//
// Purpose: Converter control and result registers behind an Avalon-MM slave
// Assumes: Analog front end returns i_sar_result when o_sar_sample is released
// Notes:   Registers answer with waitrequest low one cycle after the request
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "adcc_defs.svh"
module adcc_top #(
    parameter bit SMALL_PACKAGE = 1'b0,
    parameter int RES_W         = 10
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_resetn,
    input  wire logic [3:0]       i_avs_address,
    input  wire logic             i_avs_read,
    input  wire logic             i_avs_write,
    input  wire logic [31:0]      i_avs_writedata,
    input  wire logic [3:0]       i_avs_byteenable,
    output logic [31:0]           o_avs_readdata,
    output logic                  o_avs_waitrequest,
    input  wire logic             i_rc_osc,
    input  wire logic [RES_W-1:0] i_sar_result,
    output logic                  o_analog_power,
    output logic                  o_chan_valid,
    output logic [4:0]            o_chan_route,
    output logic                  o_sar_sample,
    output logic                  o_irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    logic rst_s1_reg;
    logic rst_n;
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_s1_reg <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n      <= rst_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // RC oscillator pin sync and divide by sixteen
    logic       rc_s1_reg;
    logic       rc_s2_reg;
    logic       rc_s3_reg;
    logic [7:0] rc_cnt_reg;
    logic [7:0] rc_cnt_next;
    logic       rc_tick;
    always_comb begin
        rc_tick     = 1'b0;
        rc_cnt_next = rc_cnt_reg;
        if (rc_s2_reg && !rc_s3_reg) begin
            if (rc_cnt_reg == `ADCC_RC_DIV - 8'h01) begin
                rc_cnt_next = 8'h00;
                rc_tick     = 1'b1; // [R05]
            end else begin
                rc_cnt_next = rc_cnt_reg + 8'h01;
            end
        end
    end
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rc_s1_reg  <= 1'b0;
            rc_s2_reg  <= 1'b0;
            rc_s3_reg  <= 1'b0;
            rc_cnt_reg <= 8'h00;
        end else begin
            rc_s1_reg  <= i_rc_osc;
            rc_s2_reg  <= rc_s1_reg;
            rc_s3_reg  <= rc_s2_reg;
            rc_cnt_reg <= rc_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [4:0]       chs_reg;
    logic [4:0]       chs_next;
    logic             en_reg;
    logic             en_next;
    logic             go_reg;
    logic             go_next;
    logic [2:0]       cks_reg;
    logic [2:0]       cks_next;
    logic [RES_W-1:0] res_reg;
    logic [RES_W-1:0] res_next;
    logic [1:0]       ist_reg;
    logic [1:0]       ist_next;
    logic [1:0]       imask_reg;
    logic [1:0]       imask_next;
    logic [31:0]      rdata_next;
    logic             wait_next;
    logic             irq_next;
    logic             sample_next;
    logic             chan_ok;
    adcc_pkg::adcc_state_e state_reg;
    adcc_pkg::adcc_state_e state_next;
    logic [3:0]       tad_cnt_reg;
    logic [3:0]       tad_cnt_next;
    logic             tad_tick;
    logic             busy_req;
    logic             wr_acc;
    logic             rd_acc;
    logic [7:0]       wb;

    // Conversion clock period ticks
    adcc_tad_gen #(
        .CNT_W(`ADCC_TAD_CNT_W)
    ) u_tad (
        .i_core_clk(i_core_clk),
        .i_rst_n   (rst_n),
        .i_run     (busy_req),
        .i_clk_sel (cks_reg),
        .i_rc_tick (rc_tick),
        .o_tad_tick(tad_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode and channel check
    always_comb begin
        busy_req = (state_reg != adcc_pkg::ADCC_IDLE);
        wr_acc   = i_avs_write && o_avs_waitrequest && !i_avs_read;
        rd_acc   = i_avs_read && o_avs_waitrequest;
        wb       = i_avs_byteenable[0] ? i_avs_writedata[7:0] : 8'h00;
        chan_ok  = (chs_reg <= `ADCC_CHS_INT_LAST) ||                      // [R01]
                   ((chs_reg >= `ADCC_CHS_EXT_FIRST) &&
                    (chs_reg <= (SMALL_PACKAGE ? `ADCC_CHS_SMALL_LAST      // [R10]
                                               : `ADCC_CHS_EXT_LAST)));
    end

    // Control, sequencer and status next values
    always_comb begin
        chs_next     = chs_reg;
        en_next      = en_reg;
        go_next      = go_reg;
        cks_next     = cks_reg;
        res_next     = res_reg;
        ist_next     = ist_reg;
        imask_next   = imask_reg;
        state_next   = state_reg;
        tad_cnt_next = tad_cnt_reg;
        sample_next  = 1'b0;
        if (wr_acc && i_avs_byteenable[0]) begin
            case (i_avs_address)
                `ADCC_ADDR_CTRL0: begin
                    chs_next = wb[`ADCC_CHS_MSB:`ADCC_CHS_LSB];            // [R08]
                    en_next  = wb[`ADCC_BIT_ENABLE];
                    if (!wb[`ADCC_BIT_ENABLE]) begin
                        go_next = 1'b0;                                    // [R03]
                    end else if (wb[`ADCC_BIT_GO] && en_reg &&
                                 state_reg == adcc_pkg::ADCC_IDLE) begin
                        go_next = 1'b1;                                    // [R02] [R17]
                    end else if (!wb[`ADCC_BIT_GO]) begin
                        go_next = 1'b0;                                    // [R15]
                    end
                end
                `ADCC_ADDR_CTRL1: cks_next = wb[`ADCC_CKS_MSB:`ADCC_CKS_LSB]; // [R04]
                `ADCC_ADDR_IRQ_MASK: imask_next = wb[1:0];
                default: ;
            endcase
        end
        // Clear first; a later hardware set wins
        if (wr_acc && i_avs_byteenable[0] && i_avs_address == `ADCC_ADDR_IRQ_STAT) begin
            ist_next = ist_reg & ~wb[1:0];                                 // [R16]
        end
        case (state_reg)
            adcc_pkg::ADCC_IDLE: begin
                tad_cnt_next = 4'h0;
                if (go_reg && en_reg) begin
                    state_next = adcc_pkg::ADCC_CONVERT;
                end
            end
            adcc_pkg::ADCC_CONVERT: begin
                if (!go_reg || !en_reg) begin
                    state_next   = adcc_pkg::ADCC_SETTLE;                  // [R15]
                    tad_cnt_next = 4'h0;
                    ist_next[`ADCC_IRQ_ABORT_BIT] = 1'b1;
                end else if (tad_tick) begin
                    if (tad_cnt_reg == `ADCC_CONV_TADS - 4'h1) begin
                        state_next = adcc_pkg::ADCC_DONE;                  // [R13]
                    end else begin
                        tad_cnt_next = tad_cnt_reg + 4'h1;
                    end
                end
            end
            adcc_pkg::ADCC_DONE: begin
                go_next                      = 1'b0;                       // [R14]
                ist_next[`ADCC_IRQ_DONE_BIT] = 1'b1;                       // [R16]
                res_next                     = chan_ok ? i_sar_result : '0;
                state_next                   = adcc_pkg::ADCC_IDLE;
            end
            adcc_pkg::ADCC_SETTLE: begin
                if (tad_tick) begin
                    if (tad_cnt_reg == `ADCC_ABORT_TADS - 4'h1) begin
                        state_next = adcc_pkg::ADCC_IDLE;
                    end else begin
                        tad_cnt_next = tad_cnt_reg + 4'h1;
                    end
                end
            end
            default: state_next = adcc_pkg::ADCC_IDLE;
        endcase
        // Sample only while a conversion is live
        sample_next = (state_next == adcc_pkg::ADCC_CONVERT) && en_next;   // [R03]
    end

    // Bus answer next values
    always_comb begin
        wait_next  = 1'b1;
        rdata_next = o_avs_readdata;
        irq_next   = |(ist_next & imask_next);
        if (rd_acc || wr_acc) begin
            wait_next = 1'b0;
        end
        if (rd_acc) begin
            case (i_avs_address)
                `ADCC_ADDR_CTRL0:    rdata_next = {25'h0, chs_reg, go_reg, en_reg}; // [R08]
                `ADCC_ADDR_CTRL1:    rdata_next = {25'h0, cks_reg, 4'h0};
                `ADCC_ADDR_RES_HIGH: rdata_next = {30'h0, res_reg[RES_W-1:8]};      // [R06]
                `ADCC_ADDR_RES_LOW:  rdata_next = {24'h0, res_reg[7:0]};            // [R07]
                `ADCC_ADDR_IRQ_STAT: rdata_next = {30'h0, ist_reg};
                `ADCC_ADDR_IRQ_MASK: rdata_next = {30'h0, imask_reg};
                default:             rdata_next = 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control and status registers
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            chs_reg           <= 5'h00;                                    // [R09]
            en_reg            <= 1'b0;
            go_reg            <= 1'b0;
            cks_reg           <= 3'h0;
            res_reg           <= '0;
            ist_reg           <= 2'h0;
            imask_reg         <= 2'h0;
        end else begin
            chs_reg           <= chs_next;
            en_reg            <= en_next;
            go_reg            <= go_next;
            cks_reg           <= cks_next;
            res_reg           <= res_next;
            ist_reg           <= ist_next;
            imask_reg         <= imask_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion sequencer
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg         <= adcc_pkg::ADCC_IDLE;
            tad_cnt_reg       <= 4'h0;
        end else begin
            state_reg         <= state_next;
            tad_cnt_reg       <= tad_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus answer and pin outputs
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_avs_readdata    <= 32'h0;
            o_avs_waitrequest <= 1'b1;
            o_irq             <= 1'b0;
            o_analog_power    <= 1'b0;
            o_chan_valid      <= 1'b0;
            o_chan_route      <= 5'h00;
            o_sar_sample      <= 1'b0;
        end else begin
            o_avs_readdata    <= rdata_next;
            o_avs_waitrequest <= wait_next;
            o_irq             <= irq_next;
            o_analog_power    <= en_next;                                  // [R03]
            o_chan_valid      <= en_next;                                  // [R12]
            o_chan_route      <= chs_next;                                 // [R01]
            o_sar_sample      <= sample_next;
        end
    end
endmodule

// ---- tb/adcc_checker.sv ----
// Purpose: Port-level assertions for the converter control block
// Assumes: Register index on i_avs_address, one core clock domain
// Notes:   Bound to every adcc_top instance
`timescale 1ns/100ps
`include "adcc_defs.svh"
module adcc_checker #(
    parameter int RES_W = 10
) (
    input wire logic             i_core_clk,
    input wire logic             i_resetn,
    input wire logic [3:0]       i_avs_address,
    input wire logic             i_avs_read,
    input wire logic             i_avs_write,
    input wire logic [31:0]      i_avs_writedata,
    input wire logic [3:0]       i_avs_byteenable,
    input wire logic [31:0]      o_avs_readdata,
    input wire logic             o_avs_waitrequest,
    input wire logic             i_rc_osc,
    input wire logic [RES_W-1:0] i_sar_result,
    input wire logic             o_analog_power,
    input wire logic             o_chan_valid,
    input wire logic [4:0]       o_chan_route,
    input wire logic             o_sar_sample,
    input wire logic             o_irq
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    logic rd_take;
    assign rd_take = i_avs_read && o_avs_waitrequest;
    ////////////////////////////////////////////////////////////////////////////////
    a_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("request not answered after one cycle");
    a_answer_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("answer held longer than one cycle");
    a_ctrl0_pad: assert property (rd_take && i_avs_address == `ADCC_ADDR_CTRL0
        |=> o_avs_readdata[31:7] == '0) else $error("control 0 upper bits not zero");
    a_ctrl1_pad: assert property (rd_take && i_avs_address == `ADCC_ADDR_CTRL1
        |=> o_avs_readdata[31:7] == '0 && o_avs_readdata[3:0] == 4'h0)
        else $error("control 1 unused bits not zero");
    a_res_high_pad: assert property (rd_take && i_avs_address == `ADCC_ADDR_RES_HIGH
        |=> o_avs_readdata[31:2] == '0) else $error("high result padding not zero");
    a_res_low_pad: assert property (rd_take && i_avs_address == `ADCC_ADDR_RES_LOW
        |=> o_avs_readdata[31:8] == '0) else $error("low result upper bits not zero");
    a_start_enabled: assert property ($rose(o_sar_sample) |-> o_analog_power)
        else $error("conversion started while disabled");
    a_off_idle: assert property (!o_analog_power && !$past(o_analog_power)
        |-> !o_sar_sample) else $error("conversion running while disabled");
    a_conv_min_len: assert property ($rose(o_sar_sample) ##1 (!i_avs_write) [*8]
        |-> o_sar_sample) else $error("conversion ended too early");
    a_hold_path: assert property (o_chan_valid == o_analog_power)
        else $error("hold path not following enable");
    c_conv_done: cover property ($fell(o_sar_sample));
    c_irq_rise: cover property ($rose(o_irq));
    c_unmapped: cover property (rd_take && i_avs_address > 4'h5);
endmodule
bind adcc_top adcc_checker #(.RES_W(RES_W)) u_chk (.*);

// ---- tb/tb_adcc_top.sv ----
// Purpose: Self-checking bench of the converter control block
// Assumes: Register index addressing, one-cycle bus answer
// Notes:   Reads note expected data in a queue; a monitor compares
`timescale 1ns/100ps
`include "adcc_defs.svh"
module tb_adcc_top;
    logic        clk = 0, rstn = 0, rd = 0, wr = 0, rc = 0;
    logic [3:0]  addr = 0, be = 4'h1;
    logic [31:0] wdata = 0, rdata, rdata_s;
    logic [9:0]  sar = 0, last_res;
    logic        wait_r, pwr, cval, samp, irq;
    logic [4:0]  route;
    logic [31:0] exp_q[$];
    logic        chk_q[$];
    int          failures = 0, cmp_count = 0, rc_cnt = 0;
    adcc_top DUT (.i_core_clk(clk), .i_resetn(rstn), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_r),
        .i_rc_osc(rc), .i_sar_result(sar), .o_analog_power(pwr), .o_chan_valid(cval),
        .o_chan_route(route), .o_sar_sample(samp), .o_irq(irq));
    adcc_top #(.SMALL_PACKAGE(1'b1)) DUT_SMALL (.i_core_clk(clk), .i_resetn(rstn),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .i_avs_byteenable(be), .o_avs_readdata(rdata_s), .o_avs_waitrequest(),
        .i_rc_osc(rc), .i_sar_result(sar), .o_analog_power(), .o_chan_valid(),
        .o_chan_route(), .o_sar_sample(), .o_irq());
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        rc_cnt <= (rc_cnt == 2) ? 0 : rc_cnt + 1;
        if (rc_cnt == 2) rc <= ~rc;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wrap_up();
        $display("Comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        if (rd && wait_r === 1'b0) begin
            if (chk_q.pop_front()) chk(rdata, exp_q.pop_front());
            else void'(exp_q.pop_front());
        end
    end
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic c,
             output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        if (!w) begin
            chk_q.push_back(c);
            exp_q.push_back(d);
        end
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= w ? d : 32'h0;
        do begin
            @(posedge clk);
            n++;
        end while (wait_r !== 1'b0 && n < 50);
        if (n >= 50) failures++;
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task w8(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, {24'h0, d}, 1'b0, q);
    endtask
    task r_exp(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, e, 1'b1, q);
    endtask
    task conv(input logic [2:0] k, input logic [4:0] ch, input int div, input logic m);
        logic [31:0] q;
        logic [9:0]  ex;
        logic [9:0]  exs;
        time         t0;
        int          cyc;
        w8(`ADCC_ADDR_CTRL1, {1'b0, k, 4'h0});
        w8(`ADCC_ADDR_CTRL0, {1'b0, ch, 2'b01});
        repeat (8) @(posedge clk);
        sar <= 10'($urandom);
        w8(`ADCC_ADDR_CTRL0, {1'b0, ch, 2'b11});
        ex = (ch <= 5'h0c || (ch >= 5'h10 && ch <= 5'h17)) ? sar : 10'h0;
        exs = (ch == 5'h16 || ch == 5'h17) ? 10'h0 : ex;
        t0 = $time;
        do bus(1'b0, `ADCC_ADDR_CTRL0, 0, 1'b0, q);
        while (q[1] !== 1'b0 && ($time - t0) < 200000);
        cyc = int'(($time - t0) / 10);
        chk(32'(cyc >= 10 * div && cyc <= 11 * div + 12), 32'h1);
        chk(q, {25'h0, ch, 2'b01});
        r_exp(`ADCC_ADDR_RES_HIGH, {30'h0, ex[9:8]});
        r_exp(`ADCC_ADDR_RES_LOW, {24'h0, ex[7:0]});
        chk(rdata_s, {24'h0, exs[7:0]});
        r_exp(`ADCC_ADDR_IRQ_STAT, 32'h1);
        chk(32'(irq), 32'(m));
        w8(`ADCC_ADDR_IRQ_STAT, 8'h01);
        r_exp(`ADCC_ADDR_IRQ_STAT, 32'h0);
        chk(32'(irq), 32'h0);
        last_res = ex;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [2:0] ks[6] = '{3'b001, 3'b101, 3'b010, 3'b110, 3'b011, 3'b111};
        int         ds[6] = '{8, 16, 32, 64, 96, 96};
        logic [4:0] cs[6] = '{5'h00, 5'h0c, 5'h0d, 5'h10, 5'h17, 5'h1f};
        void'($urandom(51857));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        r_exp(`ADCC_ADDR_CTRL0, 32'h0);
        r_exp(`ADCC_ADDR_CTRL1, 32'h0);
        r_exp(4'h9, 32'h0);
        w8(`ADCC_ADDR_CTRL1, 8'hff);
        r_exp(`ADCC_ADDR_CTRL1, 32'h70);
        be <= 4'h0;
        w8(`ADCC_ADDR_CTRL1, 8'h00);
        be <= 4'h1;
        r_exp(`ADCC_ADDR_CTRL1, 32'h70);
        w8(`ADCC_ADDR_CTRL0, 8'h02);
        r_exp(`ADCC_ADDR_CTRL0, 32'h0);
        chk(32'(pwr), 32'h0);
        chk(32'(cval), 32'h0);
        w8(`ADCC_ADDR_CTRL0, 8'hff);
        r_exp(`ADCC_ADDR_CTRL0, 32'h7d);
        chk(32'(route), 32'h1f);
        chk(32'(pwr), 32'h1);
        chk(32'(cval), 32'h1);
        for (int i = 0; i < 6; i++) begin
            if (i == 4) w8(`ADCC_ADDR_IRQ_MASK, 8'h01);
            conv(ks[i], cs[i], ds[i], i >= 4);
        end
        w8(`ADCC_ADDR_CTRL1, 8'h60);
        sar <= ~last_res;
        w8(`ADCC_ADDR_CTRL0, 8'h41);
        repeat (8) @(posedge clk);
        w8(`ADCC_ADDR_CTRL0, 8'h43);
        repeat (20) @(posedge clk);
        chk(32'(samp), 32'h1);
        w8(`ADCC_ADDR_CTRL0, 8'h41);
        w8(`ADCC_ADDR_CTRL0, 8'h43);
        r_exp(`ADCC_ADDR_CTRL0, 32'h41);
        chk(32'(samp), 32'h0);
        r_exp(`ADCC_ADDR_RES_LOW, {24'h0, last_res[7:0]});
        r_exp(`ADCC_ADDR_IRQ_STAT, 32'h2);
        wrap_up();
    end
    initial begin
        #400000;
        failures++;
        wrap_up();
    end
endmodule
